/* logic/mcf_handler.sv */
// Command frame interpreter: takes link bytes, hands the core to an executor, sends the reply.
// Assumes a byte serializer outside that pulses RX bytes and accepts TX bytes on TX_READY_IN.
`timescale 1ns/1ps
module mcf_handler (
   input wire logic CLOCK_IN,
   input wire logic RST_IN,
   input wire logic CAN_MODE_IN,
   input wire logic [7:0] MODULE_ADDR_IN,
   input wire logic [7:0] REPLY_ADDR_IN,
   input wire logic RX_VALID_IN,
   input wire logic [7:0] RX_BYTE_IN,
   output logic CMD_VALID_OUT,
   output logic [7:0] CMD_NUM_OUT,
   output logic [7:0] CMD_TYPE_OUT,
   output logic [7:0] CMD_MOTOR_OUT,
   output logic [31:0] CMD_VALUE_OUT,
   input wire logic EXEC_DONE_IN,
   input wire logic [7:0] EXEC_STATUS_IN,
   input wire logic [31:0] EXEC_VALUE_IN,
   output logic TX_VALID_OUT,
   output logic [7:0] TX_BYTE_OUT,
   output logic TX_LAST_OUT,
   input wire logic TX_READY_IN,
   output logic BUSY_OUT
);
   typedef enum {
      S_RECV,
      S_EXEC,
      S_BUILD,
      S_SEND
   } mcf_state_t;

   mcf_state_t state_q;
   logic [3:0] rx_cnt_q;
   logic [7:0] sum_q;
   logic [7:0] addr_ok_q;
   logic [7:0] frame_q [8];
   logic [11:0] gap_q;
   logic sum_bad_q;
   logic [7:0] rep_status_q;
   logic [31:0] rep_value_q;
   logic [3:0] build_idx_q;
   logic [7:0] build_sum_q;
   logic can_q;
   logic [3:0] rd_idx_q;
   logic [3:0] tx_len_q;
   logic [7:0] rd_data;
   logic buf_wr;
   logic [7:0] buf_wdata;
   logic rd_ok_q;
   logic [3:0] rx_len;
   logic [3:0] core_base;
   logic frame_end;

   function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
      add8 = 8'(a + b); // (R7)
   endfunction

   assign rx_len = CAN_MODE_IN ? 4'(mcf_pkg::CORE_BYTES) : 4'(mcf_pkg::SER_CMD_BYTES); // (R5)
   assign core_base = can_q ? 4'h0 : 4'h1; // (R8)
   assign frame_end = RX_VALID_IN && (rx_cnt_q == rx_len - 4'h1);

   // Receive path; bytes that arrive while busy are ignored since the host must wait
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         rx_cnt_q <= 4'h0;
         sum_q <= 8'h00;
         gap_q <= 12'h000;
         can_q <= 1'b0;
         addr_ok_q <= 8'h00;
      end else if (state_q == S_RECV) begin // (R3)
         if (RX_VALID_IN) begin
            gap_q <= 12'h000;
            if (rx_cnt_q == 4'h0) begin
               can_q <= CAN_MODE_IN;
            end
            if (frame_end) begin
               rx_cnt_q <= 4'h0;
               sum_q <= 8'h00;
            end else begin
               rx_cnt_q <= rx_cnt_q + 4'h1;
               sum_q <= add8(sum_q, RX_BYTE_IN); // (R7)
            end
            if (rx_cnt_q < 4'h8) begin
               frame_q[rx_cnt_q[2:0]] <= RX_BYTE_IN;
            end
            if (rx_cnt_q == 4'h0) begin
               addr_ok_q <= RX_BYTE_IN;
            end
         end else if (rx_cnt_q != 4'h0) begin
            // Stale partial frames would misalign every following command
            if (gap_q == 12'(mcf_pkg::GAP_CYCLES - 1)) begin
               rx_cnt_q <= 4'h0;
               sum_q <= 8'h00;
               gap_q <= 12'h000;
            end else begin
               gap_q <= gap_q + 12'h001;
            end
         end
      end
   end

   // Frame sequencing
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         state_q <= S_RECV;
         sum_bad_q <= 1'b0;
         CMD_VALID_OUT <= 1'b0;
         CMD_NUM_OUT <= 8'h00;
         CMD_TYPE_OUT <= 8'h00;
         CMD_MOTOR_OUT <= 8'h00;
         CMD_VALUE_OUT <= 32'h0000_0000;
         rep_status_q <= 8'h00;
         rep_value_q <= 32'h0000_0000;
         BUSY_OUT <= 1'b0;
      end else begin
         CMD_VALID_OUT <= 1'b0;
         case (state_q)
            S_RECV: begin
               if (frame_end) begin
                  if (!CAN_MODE_IN && (addr_ok_q != MODULE_ADDR_IN)) begin
                     state_q <= S_RECV; // (R15)
                  end else if (!CAN_MODE_IN && (RX_BYTE_IN != sum_q)) begin
                     sum_bad_q <= 1'b1; // (R14)
                     rep_status_q <= mcf_pkg::ST_BAD_SUM; // (R13)
                     rep_value_q <= 32'h0000_0000;
                     state_q <= S_BUILD;
                     BUSY_OUT <= 1'b1;
                  end else begin
                     state_q <= S_EXEC;
                     BUSY_OUT <= 1'b1;
                  end
               end
            end
            S_EXEC: begin
               if (!CMD_VALID_OUT && !sum_bad_q && rep_status_q != 8'hFF) begin
                  CMD_NUM_OUT <= frame_q[core_base[2:0]]; // (R4)
                  CMD_TYPE_OUT <= frame_q[3'(core_base + 4'h1)];
                  CMD_MOTOR_OUT <= frame_q[3'(core_base + 4'h2)];
                  CMD_VALUE_OUT <= can_q ? {frame_q[3], frame_q[4], frame_q[5], frame_q[6]}
                     : {frame_q[4], frame_q[5], frame_q[6], frame_q[7]}; // (R6)
                  CMD_VALID_OUT <= 1'b1;
                  rep_status_q <= 8'hFF;
               end
               if (EXEC_DONE_IN && rep_status_q == 8'hFF) begin
                  rep_status_q <= EXEC_STATUS_IN; // (R12)
                  rep_value_q <= EXEC_VALUE_IN;
                  state_q <= S_BUILD; // (R1)
               end
            end
            S_BUILD: begin
               if (build_idx_q == 4'h9) begin
                  state_q <= S_SEND;
               end
            end
            S_SEND: begin
               if (TX_VALID_OUT && TX_READY_IN && TX_LAST_OUT) begin
                  state_q <= S_RECV;
                  sum_bad_q <= 1'b0;
                  rep_status_q <= 8'h00;
                  BUSY_OUT <= 1'b0;
               end
            end
            default: state_q <= S_RECV;
         endcase
      end
   end

   // Reply assembly into the buffer; serial replies carry a leading pair and a trailing sum
   always_comb begin
      buf_wdata = 8'h00;
      case (build_idx_q)
         4'h0: buf_wdata = REPLY_ADDR_IN; // (R9)
         4'h1: buf_wdata = MODULE_ADDR_IN;
         4'h2: buf_wdata = rep_status_q;
         4'h3: buf_wdata = sum_bad_q ? frame_q[1] : CMD_NUM_OUT;
         4'h4: buf_wdata = rep_value_q[31:24]; // (R6)
         4'h5: buf_wdata = rep_value_q[23:16];
         4'h6: buf_wdata = rep_value_q[15:8];
         4'h7: buf_wdata = rep_value_q[7:0];
         4'h8: buf_wdata = build_sum_q; // (R10)
         default: buf_wdata = 8'h00;
      endcase
   end

   assign buf_wr = (state_q == S_BUILD) && (build_idx_q != 4'h9);

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         build_idx_q <= 4'h0;
         build_sum_q <= 8'h00;
      end else if (buf_wr) begin
         build_idx_q <= build_idx_q + 4'h1;
         build_sum_q <= add8(build_sum_q, buf_wdata); // (R10)
      end else if (state_q != S_BUILD) begin
         build_idx_q <= 4'h0;
         build_sum_q <= 8'h00;
      end
   end

   mcf_reply_buf #(
      .DEPTH(mcf_pkg::SER_REPLY_BYTES)
   ) u_buf (
      .clk(CLOCK_IN),
      .wr_en(buf_wr),
      .wr_addr(build_idx_q),
      .wr_data(buf_wdata),
      .rd_addr(rd_idx_q),
      .rd_data(rd_data)
   );

   // Transmit; CAN replies skip the two address bytes and the sum
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         rd_idx_q <= 4'h0;
         tx_len_q <= 4'h0;
         rd_ok_q <= 1'b0;
         TX_VALID_OUT <= 1'b0;
         TX_BYTE_OUT <= 8'h00;
         TX_LAST_OUT <= 1'b0;
      end else if (state_q != S_SEND) begin // (R2)
         rd_idx_q <= can_q ? 4'h2 : 4'h0; // (R11)
         tx_len_q <= can_q ? 4'(mcf_pkg::CAN_REPLY_BYTES) : 4'(mcf_pkg::SER_REPLY_BYTES);
         rd_ok_q <= 1'b0;
         TX_VALID_OUT <= 1'b0;
         TX_LAST_OUT <= 1'b0;
      end else if (!TX_VALID_OUT && !rd_ok_q) begin
         rd_ok_q <= 1'b1;
      end else if (rd_ok_q) begin
         rd_ok_q <= 1'b0;
         TX_VALID_OUT <= 1'b1;
         TX_BYTE_OUT <= rd_data;
         TX_LAST_OUT <= (tx_len_q == 4'h1);
         rd_idx_q <= rd_idx_q + 4'h1;
         tx_len_q <= tx_len_q - 4'h1;
      end else if (TX_READY_IN) begin
         TX_VALID_OUT <= 1'b0;
         TX_LAST_OUT <= 1'b0;
      end
   end
endmodule

/* logic/mcf_reply_buf.sv */
// Nine-byte reply frame store, written once per reply, read byte by byte.
// Assumes one write and one read port on the same clock; read data is registered.
`timescale 1ns/1ps
module mcf_reply_buf #(
   parameter int DEPTH = 9
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [3:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end
endmodule

/* shared/mcf_pkg.sv */
// Constants for the motion command frame handler: framing, status codes, timing.
// Assumes a byte-wide link front end; the serializer itself lives outside.
// Functional notes
// (R1) Each command is fully carried out before exactly one reply frame is sent.
// (R2) The block stays receiving and only drives the link to send a reply to a received command.
// (R3) The host sends no new command until it has the reply to the previous one.
// (R4) A command core is command, type, motor or bank, then a four-byte value: seven bytes.
// (R5) A serial frame is address byte, seven-byte core, checksum byte: nine bytes.
// (R6) The four-byte value travels most significant byte first in commands and replies.
// (R7) The command checksum is the 8-bit wrapping sum of all earlier bytes, address included.
// (R8) Over CAN the command has no address or checksum byte; the identifier is the address.
// (R9) A serial reply is reply address, module address, status, command number, value, checksum.
// (R10) The reply checksum is the 8-bit wrapping sum of all other reply bytes.
// (R11) Over CAN the reply has no address or checksum byte; the identifier is the reply address.
// (R12) Status is 100 for successful execution and 101 for a command stored in program memory.
// (R13) Error codes: 1 bad sum, 2 bad command, 3 wrong type, 4 bad value, 5 locked, 6 unavailable.
// (R14) On a checksum mismatch the command is not executed and status 1 is returned.
// (R15) Serial frames for another module address are dropped without a reply.
package mcf_pkg;
   localparam int CORE_BYTES = 7;
   localparam int SER_CMD_BYTES = 9;
   localparam int SER_REPLY_BYTES = 9;
   // CAN replies carry status, command and value only; the bus CRC stands in for the sum
   localparam int CAN_REPLY_BYTES = 6;
   localparam logic [7:0] ST_OK = 8'h64;
   localparam logic [7:0] ST_STORED = 8'h65;
   localparam logic [7:0] ST_BAD_SUM = 8'h01;
   localparam logic [7:0] ST_BAD_CMD = 8'h02;
   localparam logic [7:0] ST_BAD_TYPE = 8'h03;
   localparam logic [7:0] ST_BAD_VALUE = 8'h04;
   localparam logic [7:0] ST_LOCKED = 8'h05;
   localparam logic [7:0] ST_UNAVAIL = 8'h06;
   localparam logic [7:0] DEF_MODULE_ADDR = 8'h01;
   localparam logic [7:0] DEF_REPLY_ADDR = 8'h02;
   // Byte gap timeout: a silent link for this long drops a partial frame
   localparam int GAP_TIMEOUT_US = 100;
   localparam int CLOCK_MHZ = 20;
   localparam int GAP_CYCLES = GAP_TIMEOUT_US * CLOCK_MHZ;
   localparam int CNT_W = 12;
endpackage

/* testbench/mcf_handler_asserts.sv */
// Checker on the handler ports.
// Assumes one clock and sync reset.
`timescale 1ns/1ps
module mcf_chk (
   input wire logic CLOCK_IN,
   input wire logic RST_IN,
   input wire logic RX_VALID_IN,
   input wire logic CMD_VALID_OUT,
   input wire logic [7:0] CMD_NUM_OUT,
   input wire logic TX_VALID_OUT,
   input wire logic [7:0] TX_BYTE_OUT,
   input wire logic TX_LAST_OUT,
   input wire logic TX_READY_IN,
   input wire logic BUSY_OUT
);
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (RST_IN);
   sequence s_acc; TX_VALID_OUT && TX_READY_IN; endsequence
   sequence s_end; s_acc ##0 TX_LAST_OUT; endsequence
   property p_hold;
      TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_BYTE_OUT);
   endproperty
   a_hold: assert property (p_hold) else $error("tx byte lost");
   property p_txb; TX_VALID_OUT |-> BUSY_OUT; endproperty
   a_txb: assert property (p_txb) else $error("tx while idle");
   property p_cmdb; CMD_VALID_OUT |-> BUSY_OUT && !TX_VALID_OUT; endproperty
   a_cmdb: assert property (p_cmdb) else $error("cmd during tx");
   property p_once; CMD_VALID_OUT |=> !CMD_VALID_OUT [*8]; endproperty
   a_once: assert property (p_once) else $error("cmd repeated");
   property p_num; CMD_VALID_OUT |=> $stable(CMD_NUM_OUT); endproperty
   a_num: assert property (p_num) else $error("cmd number moved");
   property p_gap; s_acc |=> !TX_VALID_OUT; endproperty
   a_gap: assert property (p_gap) else $error("no gap after byte");
   property p_end; s_end |-> ##[1:2] !BUSY_OUT; endproperty
   a_end: assert property (p_end) else $error("busy after reply");
   property p_fell; $fell(BUSY_OUT) |-> $past(TX_LAST_OUT) || $past(TX_LAST_OUT, 2); endproperty
   a_fell: assert property (p_fell) else $error("busy ended early");
   property p_rx; CMD_VALID_OUT |-> $past(RX_VALID_IN, 2); endproperty
   a_rx: assert property (p_rx) else $error("cmd without frame");
endmodule
bind mcf_handler mcf_chk u_chk (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .RX_VALID_IN(RX_VALID_IN),
   .CMD_VALID_OUT(CMD_VALID_OUT), .CMD_NUM_OUT(CMD_NUM_OUT), .TX_VALID_OUT(TX_VALID_OUT),
   .TX_BYTE_OUT(TX_BYTE_OUT), .TX_LAST_OUT(TX_LAST_OUT), .TX_READY_IN(TX_READY_IN),
   .BUSY_OUT(BUSY_OUT));

/* testbench/mcf_host_model.sv */
// Host model: sends command bytes, collects reply bytes.
// Assumes the handler byte ports; drives at falling edges.
`timescale 1ns/1ps
module mcf_host_model (
   input wire logic clk,
   input wire logic slow,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_last,
   output logic tx_ready
);
   logic [7:0] rep [$];
   logic lst [$];
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b0;
   end
   // A stalling host drops ready every other cycle
   always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
   always @(posedge clk) begin
      if (tx_valid && tx_ready) begin
         rep.push_back(tx_byte);
         lst.push_back(tx_last);
      end
   end
   // Only called once the previous reply is complete
   task send(input logic [7:0] f [9], input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_byte = f[i];
         @(negedge clk);
         rx_valid = 1'b0;
         rx_byte = ~f[i];
      end
   endtask
endmodule

/* testbench/tb_top.sv */
// Bench: host model, executor stub, scenarios.
// Assumes a 20 MHz clock; inputs move at falling edges.
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] ma = 8'h21;
   localparam logic [7:0] ra = 8'h3C;
   logic clk = 1'b0, rst = 1'b1, can = 1'b0, slow = 1'b0, done = 1'b0;
   logic rxv, cmv, txv, txr, txl, busy;
   logic [7:0] es = 8'h00, rxb, cn, ct, cm, txb;
   logic [31:0] ev = 32'h0, cv;
   logic [7:0] f [9];
   int err_total = 0, n_tests = 0, ncmd = 0;
   mcf_handler DUT (.CLOCK_IN(clk), .RST_IN(rst), .CAN_MODE_IN(can), .MODULE_ADDR_IN(ma),
      .REPLY_ADDR_IN(ra), .RX_VALID_IN(rxv), .RX_BYTE_IN(rxb), .CMD_VALID_OUT(cmv),
      .CMD_NUM_OUT(cn), .CMD_TYPE_OUT(ct), .CMD_MOTOR_OUT(cm), .CMD_VALUE_OUT(cv),
      .EXEC_DONE_IN(done), .EXEC_STATUS_IN(es), .EXEC_VALUE_IN(ev), .TX_VALID_OUT(txv),
      .TX_BYTE_OUT(txb), .TX_LAST_OUT(txl), .TX_READY_IN(txr), .BUSY_OUT(busy));
   mcf_host_model u_host (.clk(clk), .slow(slow), .rx_valid(rxv), .rx_byte(rxb),
      .tx_valid(txv), .tx_byte(txb), .tx_last(txl), .tx_ready(txr));
   initial forever #25 clk = ~clk;
   // Executor answers one cycle after each command
   always @(negedge clk) begin
      done <= cmv;
      ncmd <= ncmd + int'(cmv);
   end
   task chk(input string s, input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", s, exp, got);
      end
   endtask
   task end_sim;
      $display("checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // One exchange; bad spoils the checksum, oth aims at another module
   task xact(input logic [7:0] c, st, input logic [31:0] v, input bit bad, oth);
      logic [7:0] s, e [9];
      logic [31:0] rv;
      int n, k, m, o, r;
      @(negedge clk);
      m = ncmd;
      n = can ? 7 : 9;
      o = can ? 2 : 0;
      r = can ? 6 : 9;
      f = '{oth ? ma + 8'h01 : ma, c, 8'h07, 8'h02, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
      s = 8'h00;
      for (int i = 0; i < 8; i++) s += f[i];
      f[8] = bad ? s + 8'h01 : s;
      if (can) for (int i = 0; i < 7; i++) f[i] = f[i + 1];
      es = st;
      ev = ~v;
      rv = bad ? 32'h0 : ev;
      u_host.rep.delete();
      u_host.lst.delete();
      u_host.send(f, n);
      for (k = 0; k < 400 && u_host.rep.size() < (oth ? 1 : r); k++) @(posedge clk);
      repeat (3) @(posedge clk);
      chk("cmd count", ncmd - m, (bad || oth) ? 0 : 1);
      chk("reply count", u_host.rep.size(), oth ? 0 : r);
      chk("busy", busy, 1'b0);
      if (oth) return;
      for (int i = 0; i < r; i++)
         chk("last flag", u_host.lst[i], i == r - 1);
      e = '{ra, ma, bad ? 8'h01 : st, c, rv[31:24], rv[23:16], rv[15:8], rv[7:0], 8'h00};
      for (int i = 0; i < 8; i++) e[8] += e[i];
      for (int i = o; i < o + 6 + 3 * int'(!can); i++)
         chk("reply byte", u_host.rep[i - o], e[i]);
      if (!bad) chk("cmd core", {cn, ct, cm}, {c, 8'h07, 8'h02});
      if (!bad) chk("cmd value", cv, v);
   endtask
   task t_codes;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         slow = i[0];
         xact(8'(i + 1), 8'(i < 2 ? 8'h64 + i : i - 1), 32'h80FF0012 + i, 1'b0, 1'b0);
      end
      slow = 1'b0;
   endtask
   task t_bad;
      xact(8'h06, 8'h64, 32'h01020304, 1'b1, 1'b0);
      xact(8'hFF, 8'h64, 32'hFFFFFFFF, 1'b0, 1'b0);
   endtask
   task t_addr;
      xact(8'h03, 8'h64, 32'h55AA55AA, 1'b0, 1'b1);
   endtask
   // A stalled partial frame must be dropped, else the next frame is read misaligned
   task t_gap;
      f = '{ma, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      u_host.send(f, 3);
      repeat (mcf_pkg::GAP_CYCLES + 4) @(negedge clk);
      xact(8'h05, 8'h64, 32'h00000042, 1'b0, 1'b0);
   endtask
   // Reset in mid-frame: outputs low, and the next frame counts from its first byte
   task t_reset;
      u_host.send(f, 4);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      chk("busy after reset", busy, 1'b0);
      chk("tx after reset", txv, 1'b0);
      chk("cmd after reset", cmv, 1'b0);
      rst = 1'b0;
      xact(8'h0C, 8'h64, 32'h12345678, 1'b0, 1'b0);
   endtask
   task t_can;
      @(negedge clk);
      can = 1'b1;
      xact(8'h0A, 8'h65, 32'hDEADBEEF, 1'b0, 1'b0);
      xact(8'h0B, 8'h04, 32'h00000100, 1'b0, 1'b0);
      @(negedge clk);
      can = 1'b0;
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      t_codes();
      t_bad();
      t_addr();
      t_gap();
      t_reset();
      t_can();
      end_sim();
   end
   initial begin
      #2000000;
      err_total++;
      end_sim();
   end
endmodule
